/* hdl/psar_top.v */
// Purpose: phy status and advertisement register bank with a small
//          negotiation sequencer, latching status and interrupt
// Assumes: line-side status inputs are asynchronous to CLOCK_I
// Notes:   read data stand in the cycle after the read strobe only
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "psar_regs.vh"

//
// Contract
// R1 - status one bits 14..11 always read one
// R2 - negotiation done reads one only when finished
// R3 - remote fault latches high until status read
// R4 - negotiation capable bit always reads one
// R5 - link bit latches low until status read
// R6 - extended registers bit always reads one
// R7 - slow mode swaps reversed receive pair, reports
// R8 - resolved speed duplex code in status three
// R9 - advertised next page reads zero, read-only
// R10 - local fault advert writable, resets zero
// R11 - pause advert field writable, resets zero
// R12 - four ability advert bits reset to one
// R13 - host keeps selector field at 00001
// R14 - advertisement sent in link pulse bursts
// R15 - done flag set, code shows mode
// R16 - read returns latches, clear after sampling
module psar_top #(
    parameter FLP_SLOT_CYC = `PSAR_FLP_SLOT_NS / `PSAR_CLK_NS,
    parameter FLP_GAP_CYC  = `PSAR_FLP_GAP_NS / `PSAR_CLK_NS
) (
    input  wire                    CLOCK_I,          // core clock
    input  wire                    RESET_I,          // synchronous reset
    input  wire [`PSAR_ADDR_W-1:0] ADDR_I,           // register index
    input  wire [15:0]             WDATA_I,          // write data
    input  wire                    WR_I,             // write strobe
    input  wire                    RD_I,             // read strobe
    output reg  [15:0]             RDATA_O,          // read data
    input  wire                    LINK_UP_I,        // line link good
    input  wire                    REMOTE_FAULT_I,   // partner fault seen
    input  wire [3:0]              PARTNER_ABIL_I,   // partner abilities
    input  wire                    PARTNER_VALID_I,  // partner word received
    input  wire                    RX_POL_REV_I,     // receive pair reversed
    output reg                     FLP_TX_O,         // link pulse out
    output reg                     RX_SWAP_O,        // swap receive pair
    output reg                     SPEED_FAST_O,     // 100 mbps selected
    output reg                     FULL_DUPLEX_O,    // full duplex selected
    output reg                     IRQ_O             // interrupt, level
);

localparam PULSE_CYC = (`PSAR_FLP_PULSE_NS + `PSAR_CLK_NS - 1) / `PSAR_CLK_NS;
localparam NSYNC     = 8;

// ==========================================================
// pin synchronisers: three flops, accept once second and third agree
wire [NSYNC-1:0] raw_pins = {RX_POL_REV_I, PARTNER_VALID_I, PARTNER_ABIL_I,
                             REMOTE_FAULT_I, LINK_UP_I};
reg  [NSYNC-1:0] sync_a;
reg  [NSYNC-1:0] sync_b;
reg  [NSYNC-1:0] sync_c;
reg  [NSYNC-1:0] pins;

genvar gi;
generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
        always @(posedge CLOCK_I)
        begin
            if (RESET_I)
            begin
                sync_a[gi] <= 1'b0;
                sync_b[gi] <= 1'b0;
                sync_c[gi] <= 1'b0;
                pins[gi]   <= 1'b0;
            end
            else
            begin
                sync_a[gi] <= raw_pins[gi];
                sync_b[gi] <= sync_a[gi];
                sync_c[gi] <= sync_b[gi];
                if (sync_b[gi] == sync_c[gi])
                    pins[gi] <= sync_c[gi];
            end
        end
    end
endgenerate

wire       link_now    = pins[0];
wire       fault_now   = pins[1];
wire [3:0] partner     = pins[5:2];
wire       partner_ok  = pins[6];
wire       pol_rev_now = pins[7];

// ==========================================================
// register port decode
wire rd_s1    = RD_I && (ADDR_I == `PSAR_OFF_STAT_ONE);
wire wr_adv   = WR_I && (ADDR_I == `PSAR_OFF_ADVERT);
wire wr_istat = WR_I && (ADDR_I == `PSAR_OFF_IRQ_STAT);
wire wr_imask = WR_I && (ADDR_I == `PSAR_OFF_IRQ_MASK);
wire wr_ctrl  = WR_I && (ADDR_I == `PSAR_OFF_CTRL);

reg [15:0]              advert;
reg [`PSAR_CTRL_W-1:0]  ctrl;
reg                     restart;
reg [`PSAR_IRQ_W-1:0]   irq_stat;
reg [`PSAR_IRQ_W-1:0]   irq_mask;

// ==========================================================
// advertisement and control registers
always @(posedge CLOCK_I)
begin
    if (RESET_I)
    begin
        advert  <= `PSAR_ADV_RESET; // R10 R11 R12
        ctrl    <= `PSAR_CTRL_RESET;
        restart <= 1'b0;
    end
    else
    begin
        // read-only bits, next page among them, never take a write
        if (wr_adv)
            advert <= WDATA_I & `PSAR_ADV_WMASK; // R9 R10 R11 R12
        restart <= wr_ctrl && WDATA_I[`PSAR_CTRL_RESTART];
        if (wr_ctrl)
        begin
            ctrl <= WDATA_I[`PSAR_CTRL_W-1:0];
            ctrl[`PSAR_CTRL_RESTART] <= 1'b0;
        end
    end
end

// ==========================================================
// negotiation sequencer
localparam ST_OFF  = 3'b001;
localparam ST_NEG  = 3'b010;
localparam ST_DONE = 3'b100;

reg  [2:0] state;
reg  [2:0] next_state;
reg  [2:0] spd_code;
reg  [2:0] next_spd_code;
wire       neg_en = ctrl[`PSAR_CTRL_NEG_EN];
wire       flp_pulse;

// priority: fast full, fast half, slow full, slow half
wire [3:0] common = partner & {advert[`PSAR_ADV_FAST_FULL], advert[`PSAR_ADV_FAST_HALF],
                               advert[`PSAR_ADV_SLOW_FULL], advert[`PSAR_ADV_SLOW_HALF]};

always @*
begin
    next_state = state;
    case (state)
        ST_OFF:
            if (neg_en)
                next_state = ST_NEG;
        ST_NEG:
            if (!neg_en)
                next_state = ST_OFF;
            else if (partner_ok && link_now)
                next_state = ST_DONE; // R15
        ST_DONE:
            if (!neg_en)
                next_state = ST_OFF;
            else if (restart || !link_now)
                next_state = ST_NEG;
        default:
            next_state = ST_OFF;
    endcase
    if (restart && neg_en)
        next_state = ST_NEG;
end

always @*
begin
    next_spd_code = spd_code;
    if (next_state == ST_OFF)
    begin
        if (ctrl[`PSAR_CTRL_MAN_FAST])
            next_spd_code = ctrl[`PSAR_CTRL_MAN_FULL] ? `PSAR_SPD_FAST_FULL
                                                      : `PSAR_SPD_FAST_HALF;
        else
            next_spd_code = ctrl[`PSAR_CTRL_MAN_FULL] ? `PSAR_SPD_SLOW_FULL
                                                      : `PSAR_SPD_SLOW_HALF;
    end
    else if (state == ST_NEG && next_state == ST_DONE)
    begin
        // no common ability falls back to the lowest mode
        if (common[3])
            next_spd_code = `PSAR_SPD_FAST_FULL; // R8 R15
        else if (common[2])
            next_spd_code = `PSAR_SPD_FAST_HALF;
        else if (common[1])
            next_spd_code = `PSAR_SPD_SLOW_FULL;
        else
            next_spd_code = `PSAR_SPD_SLOW_HALF;
    end
end

always @(posedge CLOCK_I)
begin
    if (RESET_I)
    begin
        state    <= ST_OFF;
        spd_code <= `PSAR_SPD_SLOW_HALF;
    end
    else
    begin
        state    <= next_state;
        spd_code <= next_spd_code;
    end
end

wire neg_done = (state == ST_DONE); // R2
wire slow     = !spd_code[1];

psar_flp_tx #(
    .SLOT_CYC  (FLP_SLOT_CYC),
    .GAP_CYC   (FLP_GAP_CYC),
    .PULSE_CYC (PULSE_CYC)
) u_flp (
    .clk_i    (CLOCK_I),
    .rst_i    (RESET_I),
    .enable_i (state == ST_NEG), // R14
    .word_i   (advert),
    .pulse_o  (flp_pulse),
    .burst_o  ()
);

// ==========================================================
// latching status bits
reg link_latched;
reg fault_latched;
reg link_prev;
reg neg_done_prev;

always @(posedge CLOCK_I)
begin
    if (RESET_I)
    begin
        link_latched  <= 1'b0;
        fault_latched <= 1'b0;
        link_prev     <= 1'b0;
        neg_done_prev <= 1'b0;
    end
    else
    begin
        link_prev     <= link_now;
        neg_done_prev <= neg_done;
        // a fault in the read cycle survives the clear
        if (fault_now)
            fault_latched <= 1'b1; // R3
        else if (rd_s1)
            fault_latched <= 1'b0; // R3 R16
        // re-arm to the present link after the read, drop wins
        if (!link_now)
            link_latched <= 1'b0; // R5
        else if (rd_s1)
            link_latched <= 1'b1; // R5 R16
    end
end

// ==========================================================
// interrupt status, mask and output
wire [`PSAR_IRQ_W-1:0] irq_event;
assign irq_event[`PSAR_IRQ_LINK]     = link_now != link_prev;
assign irq_event[`PSAR_IRQ_RFAULT]   = fault_now && !fault_latched;
assign irq_event[`PSAR_IRQ_NEG_DONE] = neg_done && !neg_done_prev;

always @(posedge CLOCK_I)
begin
    if (RESET_I)
    begin
        irq_stat <= {`PSAR_IRQ_W{1'b0}};
        irq_mask <= {`PSAR_IRQ_W{1'b0}};
        IRQ_O    <= 1'b0;
    end
    else
    begin
        // set wins over a write-one clear in the same cycle
        irq_stat <= (irq_stat & ~(wr_istat ? WDATA_I[`PSAR_IRQ_W-1:0]
                                            : {`PSAR_IRQ_W{1'b0}})) | irq_event;
        if (wr_imask)
            irq_mask <= WDATA_I[`PSAR_IRQ_W-1:0];
        IRQ_O <= |(irq_stat & irq_mask);
    end
end

// ==========================================================
// read data assembly
reg [15:0] stat_one;
reg [15:0] stat_two;
reg [15:0] stat_three;

always @*
begin
    stat_one = `PSAR_S1_FIXED; // R1 R4 R6
    stat_one[`PSAR_S1_NEG_DONE] = neg_done; // R2
    stat_one[`PSAR_S1_RFAULT]   = fault_latched; // R16
    stat_one[`PSAR_S1_LINK]     = link_latched; // R16
    stat_two = `PSAR_S2_FIXED;
    stat_two[`PSAR_S2_RXREV] = RX_SWAP_O; // R7
    stat_three = `PSAR_S3_FIXED;
    stat_three[`PSAR_S3_SPD_MSB:`PSAR_S3_SPD_LSB] = spd_code; // R8
end

always @(posedge CLOCK_I)
begin
    if (RESET_I)
        RDATA_O <= 16'h0000;
    else if (RD_I)
    begin
        case (ADDR_I)
            `PSAR_OFF_STAT_ONE: RDATA_O <= stat_one;
            `PSAR_OFF_STAT_TWO: RDATA_O <= stat_two;
            `PSAR_OFF_STAT_THR: RDATA_O <= stat_three;
            `PSAR_OFF_ADVERT:   RDATA_O <= advert;
            `PSAR_OFF_IRQ_STAT: RDATA_O <= {13'h0000, irq_stat};
            `PSAR_OFF_IRQ_MASK: RDATA_O <= {13'h0000, irq_mask};
            `PSAR_OFF_CTRL:     RDATA_O <= {12'h000, ctrl};
            default:            RDATA_O <= 16'h0000;
        endcase
    end
    else
        RDATA_O <= 16'h0000;
end

// ==========================================================
// line-side outputs
always @(posedge CLOCK_I)
begin
    if (RESET_I)
    begin
        FLP_TX_O      <= 1'b0;
        RX_SWAP_O     <= 1'b0;
        SPEED_FAST_O  <= 1'b0;
        FULL_DUPLEX_O <= 1'b0;
    end
    else
    begin
        FLP_TX_O      <= flp_pulse; // R14
        // polarity is only corrected at 10 mbps; 100 mbps is not polarised
        RX_SWAP_O     <= slow && pol_rev_now; // R7
        SPEED_FAST_O  <= spd_code[1];
        FULL_DUPLEX_O <= spd_code[2];
    end
end

endmodule
`default_nettype wire

/* hdl/psar_regs.vh */
// Purpose: register map, field positions, reset values and timing for the
//          phy status and advertisement register bank
// Assumes: 250 MHz core clock
// Notes:   definitions only
`ifndef PSAR_REGS_VH
`define PSAR_REGS_VH

// ==========================================================
// register indices on the plain register port
`define PSAR_ADDR_W        4
`define PSAR_OFF_STAT_ONE  4'h0
`define PSAR_OFF_STAT_TWO  4'h1
`define PSAR_OFF_STAT_THR  4'h2
`define PSAR_OFF_ADVERT    4'h3
`define PSAR_OFF_IRQ_STAT  4'h4
`define PSAR_OFF_IRQ_MASK  4'h5
`define PSAR_OFF_CTRL      4'h6

// ==========================================================
// status one fields
`define PSAR_S1_CAP_MSB    14
`define PSAR_S1_CAP_LSB    11
`define PSAR_S1_NEG_DONE   5
`define PSAR_S1_RFAULT     4
`define PSAR_S1_NEG_CAP    3
`define PSAR_S1_LINK       2
`define PSAR_S1_EXTENDED_REGS_PRESENT    0
`define PSAR_S1_FIXED      16'h7809

// status two and three fields
`define PSAR_S2_RXREV      4
`define PSAR_S2_FIXED      16'h000b
`define PSAR_S3_SPD_MSB    4
`define PSAR_S3_SPD_LSB    2
`define PSAR_S3_FIXED      16'h0040

// resolved speed and duplex codes
`define PSAR_SPD_FAST_FULL 3'h6
`define PSAR_SPD_SLOW_FULL 3'h5
`define PSAR_SPD_FAST_HALF 3'h2
`define PSAR_SPD_SLOW_HALF 3'h1

// ==========================================================
// advertisement fields
`define PSAR_ADV_RESET     16'h01e1
`define PSAR_ADV_WMASK     16'h2dff
`define PSAR_ADV_FAST_FULL 8
`define PSAR_ADV_FAST_HALF 7
`define PSAR_ADV_SLOW_FULL 6
`define PSAR_ADV_SLOW_HALF 5

// control fields
`define PSAR_CTRL_NEG_EN   0
`define PSAR_CTRL_RESTART  1
`define PSAR_CTRL_MAN_FAST 2
`define PSAR_CTRL_MAN_FULL 3
`define PSAR_CTRL_RESET    4'h1
`define PSAR_CTRL_W        4

// interrupt events
`define PSAR_IRQ_W         3
`define PSAR_IRQ_LINK      0
`define PSAR_IRQ_RFAULT    1
`define PSAR_IRQ_NEG_DONE  2

// ==========================================================
// link pulse timing
`define PSAR_CLK_NS        4
`define PSAR_FLP_PULSE_NS  100
`define PSAR_FLP_SLOT_NS   31250
`define PSAR_FLP_GAP_NS    16000000
`define PSAR_FLP_SLOTS     34

`endif

/* hdl/psar_flp_tx.v */
// Purpose: sends the advertisement word as fast link pulse bursts
// Assumes: word is stable while a burst is running
// Notes:   17 clock pulses interleaved with 16 data positions, lsb first
`timescale 1ns/1ns
`default_nettype none
`include "psar_regs.vh"

module psar_flp_tx #(
    parameter SLOT_CYC  = 7812,
    parameter GAP_CYC   = 4000000,
    parameter PULSE_CYC = 25
) (
    input  wire        clk_i,     // core clock
    input  wire        rst_i,     // synchronous reset
    input  wire        enable_i,  // negotiation running
    input  wire [15:0] word_i,    // advertisement word
    output reg         pulse_o,   // link pulse out
    output reg         burst_o    // one cycle at end of burst
);

// ==========================================================
// slot sequencing
reg        in_burst;
reg [5:0]  slot;
reg [31:0] cnt;
wire       odd_slot  = slot[0];
wire [3:0] bit_index = slot[4:1];
// the last slot is a quiet tail; without the guard it would resend bit 0
wire       want      = odd_slot ? (word_i[bit_index] && (slot < `PSAR_FLP_SLOTS - 1)) : 1'b1;

always @(posedge clk_i)
begin
    burst_o <= 1'b0;
    if (rst_i || !enable_i)
    begin
        in_burst <= 1'b0;
        slot     <= 6'h00;
        cnt      <= 32'h0;
        pulse_o  <= 1'b0;
    end
    else if (!in_burst)
    begin
        pulse_o <= 1'b0;
        if (cnt >= GAP_CYC - 1)
        begin
            cnt      <= 32'h0;
            in_burst <= 1'b1;
        end
        else
            cnt <= cnt + 32'h1;
    end
    else
    begin
        // pulse only in the head of each slot, gap keeps bursts spaced
        pulse_o <= want && (cnt < PULSE_CYC);
        if (cnt >= SLOT_CYC - 1)
        begin
            cnt <= 32'h0;
            if (slot == `PSAR_FLP_SLOTS - 1)
            begin
                slot     <= 6'h00;
                in_burst <= 1'b0;
                burst_o  <= 1'b1;
            end
            else
                slot <= slot + 6'h01;
        end
        else
            cnt <= cnt + 32'h1;
    end
end

endmodule
`default_nettype wire

/* sim/psar_line_model.sv */
// Purpose: link partner and line model beside the register bank
// Assumes: bench sets the line state through the cmd ports
// Notes:   answers only after one whole pulse burst was heard
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// line model
module psar_line_model (
    input  wire logic       clk_i,    // core clock
    input  wire logic       rst_i,    // sync reset
    input  wire logic       flp_i,    // pulses from device
    input  wire logic       link_i,   // cmd link
    input  wire logic       fault_i,  // cmd fault
    input  wire logic       rev_i,    // cmd reversed pair
    input  wire logic       answer_i, // cmd partner replies
    input  wire logic [3:0] abil_i,   // cmd abilities
    output logic            link_o,   // link good
    output logic            fault_o,  // remote fault
    output logic            rev_o,    // pair reversed
    output logic            valid_o,  // word received
    output logic [3:0]      abil_o,   // abilities
    output logic [7:0]      pulses_o  // pulses in last burst
);
    logic [7:0] cnt;
    logic [7:0] idle;
    logic       flp_q;
    logic       heard;
    always @(posedge clk_i)
    begin
        flp_q   <= flp_i;
        link_o  <= link_i;
        fault_o <= fault_i;
        rev_o   <= rev_i;
        abil_o  <= abil_i;
        valid_o <= answer_i && heard && link_i;
        if (rst_i)
        begin
            cnt      <= 8'h00;
            idle     <= 8'h00;
            heard    <= 1'b0;
            pulses_o <= 8'h00;
        end
        else
        begin
            if (flp_i && !flp_q)
            begin
                cnt  <= cnt + 8'h01;
                idle <= 8'h00;
            end
            else if (idle != 8'hff)
                idle <= idle + 8'h01;
            // a burst ends after a quiet spell longer than any slot gap
            if (idle == 8'ha0 && cnt != 8'h00)
            begin
                pulses_o <= cnt;
                cnt      <= 8'h00;
                heard    <= 1'b1;
            end
            if (!answer_i)
                heard <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* sim/psar_top_checker.sv */
// Purpose: port-level checks of the register bank
// Assumes: line inputs held steady around reads
// Notes:   bound to psar_top
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// checker
module psar_top_checker (
    input wire logic        CLOCK_I,        // clock
    input wire logic        RESET_I,        // reset
    input wire logic [3:0]  ADDR_I,         // index
    input wire logic [15:0] WDATA_I,        // wdata
    input wire logic        WR_I,           // write
    input wire logic        RD_I,           // read
    input wire logic [15:0] RDATA_O,        // rdata
    input wire logic        LINK_UP_I,      // link
    input wire logic        REMOTE_FAULT_I, // fault
    input wire logic        RX_SWAP_O,      // swap
    input wire logic        SPEED_FAST_O,   // fast
    input wire logic        FULL_DUPLEX_O,  // full
    input wire logic        IRQ_O           // irq
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data not zero outside read");
    caps_fixed_a: assert property ($past(RD_I) && $past(ADDR_I) == 4'h0
        |-> RDATA_O[15:11] == 5'h0f && RDATA_O[3] && RDATA_O[0])
        else $error("fixed status one bits wrong");
    adv_fixed_a: assert property ($past(RD_I) && $past(ADDR_I) == 4'h3
        |-> RDATA_O[15:14] == 2'h0 && !RDATA_O[12] && !RDATA_O[9])
        else $error("advert read-only bits wrong");
    code_match_a: assert property ($past(RD_I) && $past(ADDR_I) == 4'h2
        |-> RDATA_O == {11'h002, FULL_DUPLEX_O, SPEED_FAST_O,
        !SPEED_FAST_O, 2'h0})
        else $error("status three code wrong");
    swap_slow_a: assert property (RX_SWAP_O |-> !SPEED_FAST_O)
        else $error("pair swapped at fast speed");
    rev_report_a: assert property ($past(RD_I) && $past(ADDR_I) == 4'h1
        |-> RDATA_O == {11'h000, $past(RX_SWAP_O), 4'hb})
        else $error("status two wrong");
    link_low_a: assert property ((!LINK_UP_I)[*8] ##1
        (RD_I && ADDR_I == 4'h0 && !LINK_UP_I) |=> !RDATA_O[2])
        else $error("link bit high while down");
    fault_high_a: assert property (REMOTE_FAULT_I[*8] ##1
        (RD_I && ADDR_I == 4'h0 && REMOTE_FAULT_I) |=> RDATA_O[4])
        else $error("fault bit low while fault");
    done_off_a: assert property ((WR_I && ADDR_I == 4'h6 && !WDATA_I[0])
        ##[2:6] (RD_I && ADDR_I == 4'h0) |=> !RDATA_O[5])
        else $error("done set while disabled");
    irq_mask_a: assert property ((WR_I && ADDR_I == 4'h5 && WDATA_I[2:0] == 3'h0)
        |-> ##2 !IRQ_O)
        else $error("irq high with mask clear");
    cover property (IRQ_O);
    cover property (RX_SWAP_O);
    cover property ($past(RD_I) && $past(ADDR_I) == 4'h0 && RDATA_O[5]);
endmodule
bind psar_top psar_top_checker psar_top_checker_i (.CLOCK_I, .RESET_I, .ADDR_I,
    .WDATA_I, .WR_I, .RD_I, .RDATA_O, .LINK_UP_I, .REMOTE_FAULT_I, .RX_SWAP_O,
    .SPEED_FAST_O, .FULL_DUPLEX_O, .IRQ_O);
`default_nettype wire

/* sim/psar_top_test.sv */
// Purpose: self-checking bench of the register bank
// Assumes: short pulse timing parameters
// Notes:   seeded random advert words
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench
module psar_top_test;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0, abil = 4'h0;
    logic [15:0] wdata = 16'h0000, rdv, d;
    logic lk = 1'b0, flt = 1'b0, rev = 1'b0, ans = 1'b0;
    wire logic [15:0] rdata;
    wire logic [3:0] l_abil;
    wire logic [7:0] pulses;
    wire logic l_lk, l_flt, l_rev, l_val, flp, swp, fast, full, irq;
    int num_errors = 0, cmp_count = 0, k;
    always #2 clk = ~clk;
    psar_top #(.FLP_SLOT_CYC(40), .FLP_GAP_CYC(200)) psar_top_i (.CLOCK_I(clk),
        .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .LINK_UP_I(l_lk), .REMOTE_FAULT_I(l_flt),
        .PARTNER_ABIL_I(l_abil), .PARTNER_VALID_I(l_val), .RX_POL_REV_I(l_rev),
        .FLP_TX_O(flp), .RX_SWAP_O(swp), .SPEED_FAST_O(fast),
        .FULL_DUPLEX_O(full), .IRQ_O(irq));
    psar_line_model psar_line_model_i (.clk_i(clk), .rst_i(rst), .flp_i(flp),
        .link_i(lk), .fault_i(flt), .rev_i(rev), .answer_i(ans), .abil_i(abil),
        .link_o(l_lk), .fault_o(l_flt), .rev_o(l_rev), .valid_o(l_val),
        .abil_o(l_abil), .pulses_o(pulses));
    task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    task bus_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task bus_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rdv = rdata;
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // priority order of the resolved mode
    function logic [15:0] exp_stat3(input logic [3:0] a);
        return a[3] ? 16'h0058 : a[2] ? 16'h0048 : a[1] ? 16'h0054 : 16'h0044;
    endfunction
    task final_report;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #160000;
        num_errors++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'h77fd9543));
        wait_cyc(6);
        rst <= 1'b0;
        bus_rd(4'h0);
        chk("stat1", rdv, 16'h7809);
        bus_rd(4'h1);
        chk("stat2", rdv, 16'h000b);
        bus_rd(4'h3);
        chk("advert", rdv, 16'h01e1);
        bus_rd(4'hf);
        chk("unmapped", rdv, 16'h0000);
        for (k = 0; k < 8; k++)
        begin
            d = $urandom;
            d[4:0] = 5'h01;
            d[11:10] = k[1:0];
            bus_wr(4'h3, d);
            bus_rd(4'h3);
            chk("advert", rdv, d & 16'h2dff);
        end
        bus_wr(4'h3, 16'h01e1);
        $display("reset and advert test done");
        lk <= 1'b1;
        for (k = 0; k < 4; k++)
        begin
            ans <= 1'b0;
            abil <= 4'h8 >> k;
            wait_cyc(8);
            bus_wr(4'h6, 16'h0003);
            wait_cyc(8);
            bus_rd(4'h0);
            chk("running", {15'h0, rdv[5]}, 16'h0000);
            ans <= 1'b1;
            for (int n = 0; n < 4000 && l_val !== 1'b1; n++)
                @(posedge clk);
            wait_cyc(12);
            chk("pulses", {8'h0, pulses}, 16'h0016);
            bus_rd(4'h0);
            chk("done", {15'h0, rdv[5]}, 16'h0001);
            bus_rd(4'h2);
            chk("stat3", rdv, exp_stat3(abil));
            rev <= 1'b1;
            wait_cyc(12);
            bus_rd(4'h1);
            d = exp_stat3(abil);
            chk("stat2", rdv, {11'h0, ~d[3], 4'hb});
            chk("swap", {15'h0, swp}, {15'h0, ~d[3]});
            rev <= 1'b0;
        end
        $display("negotiation test done");
        bus_rd(4'h0);
        bus_rd(4'h0);
        chk("link", {15'h0, rdv[2]}, 16'h0001);
        lk <= 1'b0;
        wait_cyc(10);
        bus_rd(4'h0);
        chk("link", {15'h0, rdv[2]}, 16'h0000);
        lk <= 1'b1;
        wait_cyc(10);
        bus_rd(4'h0);
        chk("link", {15'h0, rdv[2]}, 16'h0000);
        bus_rd(4'h0);
        chk("link", {15'h0, rdv[2]}, 16'h0001);
        flt <= 1'b1;
        wait_cyc(10);
        bus_rd(4'h0);
        chk("fault", {15'h0, rdv[4]}, 16'h0001);
        flt <= 1'b0;
        wait_cyc(10);
        bus_rd(4'h0);
        chk("fault", {15'h0, rdv[4]}, 16'h0001);
        bus_rd(4'h0);
        chk("fault", {15'h0, rdv[4]}, 16'h0000);
        $display("latch test done");
        bus_wr(4'h5, 16'h0000);
        bus_wr(4'h4, 16'h0007);
        lk <= 1'b0;
        wait_cyc(10);
        chk("irq", {15'h0, irq}, 16'h0000);
        bus_wr(4'h5, 16'h0001);
        wait_cyc(3);
        chk("irq", {15'h0, irq}, 16'h0001);
        bus_wr(4'h4, 16'h0001);
        wait_cyc(3);
        chk("irq", {15'h0, irq}, 16'h0000);
        lk <= 1'b1;
        wait_cyc(10);
        chk("irq", {15'h0, irq}, 16'h0001);
        bus_wr(4'h5, 16'h0000);
        wait_cyc(3);
        chk("irq", {15'h0, irq}, 16'h0000);
        bus_rd(4'h4);
        chk("irqstat", rdv, 16'h0005);
        $display("irq test done");
        bus_wr(4'h6, 16'h000c);
        wait_cyc(2);
        bus_rd(4'h0);
        chk("manual", {15'h0, rdv[5]}, 16'h0000);
        bus_rd(4'h2);
        chk("manual", rdv, 16'h0058);
        bus_wr(4'h6, 16'h0008);
        wait_cyc(2);
        bus_rd(4'h2);
        chk("manual", rdv, 16'h0054);
        $display("manual test done");
        final_report();
    end
endmodule
`default_nettype wire
